// ### core/led_pkg.sv
`default_nettype none
package led_pkg;
  // Clock rate and derived timing.
  localparam int CLK_HZ = 50_000_000;
  localparam int SELFTEST_S = 15;
  localparam int SELFTEST_CYC = SELFTEST_S * CLK_HZ;
  localparam int PERIOD_MS = 1000;
  localparam int SLOTS = 16;
  localparam int SLOT_CYC = PERIOD_MS * (CLK_HZ / 1000) / SLOTS;
  // Register byte offsets.
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // Control fields and reset value.
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_NEW_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  // Status fields.
  localparam int STAT_BOOT_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_SLOT_LSB = 4;
  // Flash counts per period.
  localparam logic [2:0] BLINK_ONE = 3'h1;
  localparam logic [2:0] BLINK_TWO = 3'h2;
  localparam logic [2:0] BLINK_THREE = 3'h3;
  localparam logic [2:0] BLINK_FOUR = 3'h4;
endpackage
`default_nettype wire

// ### core/status_led_controller.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - After reset, run a roughly fifteen second self-test showing indicator patterns.
// - Dual supply: green both present, yellow one present, dark none.
// - Single supply: green while present, dark while too low.
// - Standby indicator green while standby enabled, dark otherwise.
// - Ring LED dark when off; green if port blocked, yellow if forwarding.
// - Misconfigured ring makes the ring LED flash green.
// - Failed memory operation flashes ring and standby LEDs alternately.
// - Load flashes ring and standby together twice per period; save once.
// - Fault LED red while signal contact open, dark while closed.
// - Newer mode: duplicate address flashes fault LED four times per period.
// - Legacy mode: relay LED yellow when closed manually, dark otherwise.
// - Newer mode: relay green open automatic, yellow open manual, dark closed.
// - Under manual control of relay one the fault LED follows the detected error.
// - Port LED flashes green once per period while port in standby.
// - Port LED flashes green three times per period while port disabled.
// - Port dark without link, green with link, yellow flash on traffic.
// - During boot the port LEDs show boot progress instead of link.
module status_led_controller #(
  parameter int NPORTS = 16,
  parameter int SELFTEST_CYC = led_pkg::SELFTEST_CYC,
  parameter int SLOT_CYC = led_pkg::SLOT_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Device status from the switch core
  input wire logic [1:0] supply_ok_i,
  input wire logic standby_en_i,
  input wire logic ring_mgr_en_i,
  input wire logic ring_port_blocked_i,
  input wire logic ring_misconfig_i,
  input wire logic cfg_error_i,
  input wire logic cfg_load_i,
  input wire logic cfg_save_i,
  input wire logic error_detect_i,
  input wire logic dup_ip_i,
  input wire logic [1:0] relay_open_i,
  input wire logic [1:0] relay_manual_i,
  // Port status from the switch core
  input wire logic [NPORTS-1:0] port_standby_i,
  input wire logic [NPORTS-1:0] port_disabled_i,
  input wire logic [NPORTS-1:0] port_link_i,
  input wire logic [NPORTS-1:0] port_activity_i,
  // Device LEDs
  output logic supply_led_g_o,
  output logic supply_led_y_o,
  output logic standby_indicator_o,
  output logic ring_manager_led_g_o,
  output logic ring_manager_led_y_o,
  output logic fault_led_o,
  output logic [1:0] relay_one_led_o,
  output logic [1:0] relay_two_led_o,
  // Port LEDs
  output logic [NPORTS-1:0] port_link_led_o,
  output logic [NPORTS-1:0] port_traffic_led_o
);

  logic [1:0] ctrl;
  logic [31:0] slot_cnt;
  logic [3:0] slot;
  logic slot_tick;
  logic [31:0] boot_cnt;
  logic boot;
  logic [7:0] chase;
  logic next_sup_g, next_sup_y, next_sby;
  logic next_rm_g, next_rm_y, next_fault;
  logic [1:0] next_r1, next_r2;
  logic fault_cond;
  logic req;
  logic [31:0] next_rd;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Lit in the first half of slot pairs 0..n-1, so n flashes per period.
  function automatic logic blink(input logic [2:0] n, input logic [3:0] s);
    blink = !s[0] && ({1'b0, s[3:1]} < {1'b0, n});
  endfunction

  // Relay LED code {yellow, green}.
  function automatic logic [1:0] relay_led(input logic newer,
                                           input logic open_c,
                                           input logic manual);
    if (newer)
      relay_led = open_c ? (manual ? 2'h2 : 2'h1) : 2'h0;
    else
      relay_led = (!open_c && manual) ? 2'h2 : 2'h0;
  endfunction

  // One divider feeds every pattern so that shared flashes stay in phase.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      slot_cnt <= 32'h0;
      slot <= 4'h0;
    end
    else if (slot_tick)
    begin
      slot_cnt <= 32'h0;
      slot <= slot + 4'h1;
    end
    else
    begin
      slot_cnt <= slot_cnt + 32'h1;
    end
  end
  assign slot_tick = (slot_cnt == 32'(SLOT_CYC - 1));

  // Boot phase timer and the progress chase over the port LEDs.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      boot_cnt <= 32'h0;
      boot <= 1'b1;
      chase <= 8'h0;
    end
    else if (boot)
    begin
      boot_cnt <= boot_cnt + 32'h1;
      boot <= (boot_cnt != 32'(SELFTEST_CYC - 1));
      if (slot_tick)
      begin
        chase <= (chase == 8'(NPORTS - 1)) ? 8'h0 : chase + 8'h1;
      end
    end
  end

  // Manual control of relay one decouples the fault LED from its contact.
  assign fault_cond = relay_manual_i[0] ? error_detect_i
                                        : relay_open_i[0];

  always_comb
  begin
    next_sup_g = 1'b0;
    next_sup_y = 1'b0;
    next_sby = 1'b0;
    next_rm_g = 1'b0;
    next_rm_y = 1'b0;
    next_fault = 1'b0;
    next_r1 = 2'h0;
    next_r2 = 2'h0;
    if (boot)
    begin
      // Lamp test: every device LED except the yellow ones toggles on the common timebase.
      next_sup_g = slot[2];
      next_sby = slot[2];
      next_rm_g = slot[2];
      next_fault = slot[2];
      next_r1 = {1'b0, slot[2]};
      next_r2 = {1'b0, slot[2]};
    end
    else
    begin
      if (ctrl[led_pkg::CTRL_DUAL_BIT])
      begin
        next_sup_g = &supply_ok_i;
        next_sup_y = ^supply_ok_i;
      end
      else
      begin
        next_sup_g = supply_ok_i[0];
      end
      if (cfg_error_i)
      begin
        next_rm_g = slot[3];
        next_sby = !slot[3];
      end
      else if (cfg_load_i)
      begin
        next_rm_g = blink(led_pkg::BLINK_TWO, slot);
        next_sby = next_rm_g;
      end
      else if (cfg_save_i)
      begin
        next_rm_g = blink(led_pkg::BLINK_ONE, slot);
        next_sby = next_rm_g;
      end
      else
      begin
        next_sby = standby_en_i;
        if (ring_misconfig_i)
        begin
          next_rm_g = slot[1];
        end
        else if (ring_mgr_en_i)
        begin
          next_rm_g = ring_port_blocked_i;
          next_rm_y = !ring_port_blocked_i;
        end
      end
      if (ctrl[led_pkg::CTRL_NEW_BIT] && dup_ip_i)
      begin
        next_fault = blink(led_pkg::BLINK_FOUR, slot);
      end
      else
      begin
        next_fault = fault_cond;
      end
      next_r1 = relay_led(ctrl[led_pkg::CTRL_NEW_BIT], relay_open_i[0],
                          relay_manual_i[0]);
      next_r2 = relay_led(ctrl[led_pkg::CTRL_NEW_BIT], relay_open_i[1],
                          relay_manual_i[1]);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      supply_led_g_o <= 1'b0;
      supply_led_y_o <= 1'b0;
      standby_indicator_o <= 1'b0;
      ring_manager_led_g_o <= 1'b0;
      ring_manager_led_y_o <= 1'b0;
      fault_led_o <= 1'b0;
      relay_one_led_o <= 2'h0;
      relay_two_led_o <= 2'h0;
    end
    else
    begin
      supply_led_g_o <= next_sup_g;
      supply_led_y_o <= next_sup_y;
      standby_indicator_o <= next_sby;
      ring_manager_led_g_o <= next_rm_g;
      ring_manager_led_y_o <= next_rm_y;
      fault_led_o <= next_fault;
      relay_one_led_o <= next_r1;
      relay_two_led_o <= next_r2;
    end
  end

  // Port LEDs; with a bicolour LED the two outputs drive its two dies.
  for (genvar i = 0; i < NPORTS; i++)
  begin : g_port
    logic next_g;
    logic next_y;
    always_comb
    begin
      next_g = 1'b0;
      next_y = 1'b0;
      if (boot)
      begin
        next_g = (chase == 8'(i));
      end
      else if (port_disabled_i[i])
      begin
        next_g = blink(led_pkg::BLINK_THREE, slot);
      end
      else if (port_standby_i[i])
      begin
        next_g = blink(led_pkg::BLINK_ONE, slot);
      end
      else if (port_link_i[i])
      begin
        // Traffic blanks green so a bicolour LED shows pure yellow.
        next_y = port_activity_i[i] && slot[0];
        next_g = !next_y;
      end
    end
    always_ff @(posedge mclk_i)
    begin
      // Reset gates the next value, so every port LED comes up dark.
      port_link_led_o[i] <= rst_n_i && next_g;
      port_traffic_led_o[i] <= rst_n_i && next_y;
    end
  end

  // Avalon slave: every access waits exactly one cycle.
  assign req = read_i || write_i;

  always_comb
  begin
    next_rd = 32'h0;
    case (address_i)
      led_pkg::CTRL_OFS: next_rd = {30'h0, ctrl};
      led_pkg::STAT_OFS:
      begin
        next_rd[led_pkg::STAT_BOOT_BIT] = boot;
        next_rd[led_pkg::STAT_FAULT_BIT] = fault_led_o;
        next_rd[led_pkg::STAT_SLOT_LSB +: 4] = slot;
      end
      default: next_rd = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h0;
    end
    else
    begin
      waitrequest_o <= !(req && waitrequest_o);
      if (read_i && waitrequest_o)
      begin
        readdata_o <= next_rd;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= led_pkg::CTRL_RST;
    end
    else if (write_i && !waitrequest_o && address_i == led_pkg::CTRL_OFS
             && byteenable_i[0])
    begin
      ctrl <= writedata_i[1:0];
    end
  end

  sequence s_idle_run;
    !boot && !cfg_error_i && !cfg_load_i && !cfg_save_i;
  endsequence

  a_wait_one: assert property (req && waitrequest_o |=> !waitrequest_o
    ##1 waitrequest_o) else $error("waitrequest not one cycle");
  a_boot_ends: assert property ($fell(boot) |-> $past(boot_cnt)
    == 32'(SELFTEST_CYC - 1)) else $error("boot length wrong");
  a_supply_dual: assert property (!boot && ctrl[0]
    && supply_ok_i == 2'h1 |=> !supply_led_g_o && supply_led_y_o)
    else $error("dual supply colour wrong");
  a_standby_led: assert property (s_idle_run ##0 standby_en_i
    |=> standby_indicator_o) else $error("standby led dark");
  a_ring_fwd: assert property (s_idle_run ##0 ring_mgr_en_i
    && !ring_misconfig_i && !ring_port_blocked_i |=> ring_manager_led_y_o)
    else $error("ring forwarding not yellow");
  a_cfg_alt: assert property (!boot && cfg_error_i
    |=> ring_manager_led_g_o != standby_indicator_o)
    else $error("memory error not alternating");
  a_load_phase: assert property (!boot && cfg_load_i
    && !cfg_error_i |=> ring_manager_led_g_o == standby_indicator_o)
    else $error("load flash out of phase");
  a_fault_manual: assert property (!boot && !dup_ip_i
    && relay_manual_i[0] |=> fault_led_o == $past(error_detect_i))
    else $error("manual fault display wrong");
  a_relay_new: assert property (!boot && ctrl[1] && !relay_open_i[1]
    |=> relay_two_led_o == 2'h0) else $error("closed relay lit");
  a_port_dark: assert property (!boot && !port_link_i[0]
    && !port_standby_i[0] && !port_disabled_i[0]
    |=> !port_link_led_o[0] && !port_traffic_led_o[0])
    else $error("port lit without link");
  a_boot_chase: assert property (rst_n_i && boot ##1 boot
    |-> $onehot(port_link_led_o) && !(|port_traffic_led_o))
    else $error("boot progress wrong");

endmodule // status_led_controller
`default_nettype wire

// ### bench/led_observer.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the operator: counts how often one indicator lights up.
module led_observer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Watched indicator
  input wire logic led_i,
  input wire logic clear_i,
  output var int flashes_o
);
  logic last;
  always_ff @(posedge mclk_i)
  begin
    last <= led_i;
    if (!rst_n_i || clear_i)
      flashes_o <= 0;
    else if (led_i && !last)
      flashes_o <= flashes_o + 1;
  end
endmodule // led_observer
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int NP = 4;
  localparam int SC = 4;
  logic mclk_i = 0, rst_n_i = 0, read_i = 0, write_i = 0, clr = 0;
  logic [3:0] address_i = 4'h0, byteenable_i = 4'hf;
  logic [31:0] writedata_i = 32'h0, lfsr = 32'h8860, q;
  logic [1:0] supply_ok_i = 0, relay_open_i = 0, relay_manual_i = 0;
  logic standby_en_i = 0, ring_mgr_en_i = 0, ring_port_blocked_i = 0;
  logic ring_misconfig_i = 0, cfg_error_i = 0, cfg_load_i = 0;
  logic cfg_save_i = 0, error_detect_i = 0, dup_ip_i = 0;
  logic [NP-1:0] port_standby_i = 0, port_disabled_i = 0;
  logic [NP-1:0] port_link_i = 0, port_activity_i = 0;
  logic [31:0] readdata_o;
  logic waitrequest_o, supply_led_g_o, supply_led_y_o, standby_indicator_o;
  logic ring_manager_led_g_o, ring_manager_led_y_o, fault_led_o;
  logic [1:0] relay_one_led_o, relay_two_led_o, ctrl = 2'h3;
  logic [NP-1:0] port_link_led_o, port_traffic_led_o;
  int fails = 0, comparisons = 0, cyc = 0, tick = 0, fcnt, pcnt;
  wire logic [9:0] devo = {supply_led_g_o, supply_led_y_o,
    standby_indicator_o, ring_manager_led_g_o, ring_manager_led_y_o,
    fault_led_o, relay_one_led_o, relay_two_led_o};

  status_led_controller #(.NPORTS(NP), .SELFTEST_CYC(256), .SLOT_CYC(SC))
  status_led_controller_i (.mclk_i, .rst_n_i, .address_i, .read_i,
    .write_i, .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
    .supply_ok_i, .standby_en_i, .ring_mgr_en_i, .ring_port_blocked_i,
    .ring_misconfig_i, .cfg_error_i, .cfg_load_i, .cfg_save_i,
    .error_detect_i, .dup_ip_i, .relay_open_i, .relay_manual_i,
    .port_standby_i, .port_disabled_i, .port_link_i, .port_activity_i,
    .supply_led_g_o, .supply_led_y_o, .standby_indicator_o,
    .ring_manager_led_g_o, .ring_manager_led_y_o, .fault_led_o,
    .relay_one_led_o, .relay_two_led_o, .port_link_led_o,
    .port_traffic_led_o);
  led_observer led_observer_i (.mclk_i, .rst_n_i, .led_i(fault_led_o),
    .clear_i(clr), .flashes_o(fcnt));
  led_observer led_observer_port_i (.mclk_i, .rst_n_i,
    .led_i(port_link_led_o[0]), .clear_i(clr), .flashes_o(pcnt));

  always #10 mclk_i = !mclk_i;
  always @(posedge mclk_i)
  begin
    cyc <= rst_n_i ? cyc + 1 : 0;
    tick <= tick + 1;
    if (tick == 5000)
    begin
      fails++;
      results();
    end
  end

  task automatic results();
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // The answer is awaited without assuming its latency.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk_i);
    read_i <= !w;
    write_i <= w;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    // Only the cycle timeout ends a wait that never sees an answer.
    do
      @(posedge mclk_i);
    while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask

  function automatic logic fl(int n, logic [3:0] s);
    return s < 2 * n && !s[0];
  endfunction

  function automatic logic [1:0] rel(logic o, logic m);
    if (ctrl[1])
      return o ? (m ? 2'b10 : 2'b01) : 2'b00;
    return {!o & m, 1'b0};
  endfunction

  function automatic logic [9:0] dev(logic [3:0] s);
    logic g, y, sb, f;
    sb = standby_en_i;
    g = ring_misconfig_i ? s[1] : ring_mgr_en_i & ring_port_blocked_i;
    y = !ring_misconfig_i & ring_mgr_en_i & !ring_port_blocked_i;
    if (cfg_error_i)
      {g, y, sb} = {s[3], 1'b0, !s[3]};
    else if (cfg_load_i)
      {g, y, sb} = {fl(2, s), 1'b0, fl(2, s)};
    else if (cfg_save_i)
      {g, y, sb} = {fl(1, s), 1'b0, fl(1, s)};
    f = relay_manual_i[0] ? error_detect_i : relay_open_i[0];
    if (ctrl[1] && dup_ip_i)
      f = fl(4, s);
    return {ctrl[0] ? &supply_ok_i : supply_ok_i[0], ctrl[0] & ^supply_ok_i,
      sb, g, y, f, rel(relay_open_i[0], relay_manual_i[0]),
      rel(relay_open_i[1], relay_manual_i[1])};
  endfunction

  function automatic logic [2*NP-1:0] prt(logic [3:0] s);
    logic [NP-1:0] l, t;
    for (int p = 0; p < NP; p++)
    begin
      t[p] = port_link_i[p] & port_activity_i[p] & s[0];
      l[p] = port_link_i[p] & !t[p];
      if (port_standby_i[p])
        {l[p], t[p]} = {fl(1, s), 1'b0};
      if (port_disabled_i[p])
        {l[p], t[p]} = {fl(3, s), 1'b0};
    end
    return {l, t};
  endfunction

  // Inputs change at a slot start and are judged mid-slot, so a one-cycle
  // skew in the slot counter cannot flip a verdict.
  task automatic step(int k);
    logic [31:0] r;
    repeat (k)
    begin
      do @(negedge mclk_i); while (cyc % SC != 3);
      @(posedge mclk_i);
      r = rnd();
      {supply_ok_i, standby_en_i, ring_port_blocked_i} <= r[3:0];
      ring_mgr_en_i <= r[4] | r[5];
      ring_misconfig_i <= r[5] & r[6];
      {cfg_error_i, cfg_load_i, cfg_save_i} <= r[9:7] & {3{r[10]}};
      {error_detect_i, relay_open_i, relay_manual_i} <= r[15:11];
      dup_ip_i <= r[16] & r[17];
      r = rnd();
      port_link_i <= r[3:0];
      port_activity_i <= r[3:0] & r[7:4];
      port_standby_i <= r[11:8] & r[15:12];
      port_disabled_i <= r[19:16] & r[23:20];
      repeat (3) @(negedge mclk_i);
      chk(devo, dev(4'((cyc / SC) % 16)));
      chk({port_link_led_o, port_traffic_led_o},
          prt(4'((cyc / SC) % 16)));
    end
  endtask

  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    port_link_i <= '1;
    bus(0, led_pkg::CTRL_OFS, 0, 4'hf);
    chk(q, 32'(led_pkg::CTRL_RST));
    bus(1, led_pkg::CTRL_OFS, 0, 4'h0);
    bus(0, led_pkg::CTRL_OFS, 0, 4'hf);
    chk(q, 32'h3);
    bus(0, 4'h8, 0, 4'hf);
    chk(q, 32'h0);
    repeat (4)
    begin
      repeat (SC) @(negedge mclk_i);
      chk(32'($countones(port_link_led_o)), 1);
    end
    wait (cyc > 240);
    bus(0, led_pkg::STAT_OFS, 0, 4'hf);
    chk(q[0], 1'b1);
    wait (cyc > 262);
    bus(0, led_pkg::STAT_OFS, 0, 4'hf);
    chk(q[0], 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      bus(1, led_pkg::CTRL_OFS, 32'(c), 4'h1);
      ctrl = 2'(c);
      bus(0, led_pkg::CTRL_OFS, 0, 4'hf);
      chk(q, 32'(c));
      step(40);
    end
    @(posedge mclk_i);
    dup_ip_i <= 1'b1;
    port_disabled_i <= '1;
    clr <= 1'b1;
    repeat (4) @(posedge mclk_i);
    clr <= 1'b0;
    repeat (64) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(fcnt, 4);
    chk(pcnt, 3);
    results();
  end
endmodule // tb
`default_nettype wire
